/* verilog/fpm_menu.sv */
// Front-panel menu, setting editor, trip test and setting banks.
`timescale 1ns/100ps
module fpm_menu #(
  parameter int TICK_CYC = fpm_pkg::TICK_CYC_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Push buttons, pins.
  input wire logic btnStep,
  input wire logic btnProg,
  // Link and supply status, pins.
  input wire logic serLinkOk,
  input wire logic supplyLost,
  // Fault capture from protection logic.
  input wire logic faultEv,
  input wire logic [11:0] faultVal,
  // Register port.
  input wire fpm_pkg::fpm_bus_t bus,
  output logic [31:0] busRdata,
  // Panel display.
  output fpm_pkg::fpm_disp_t disp,
  // Outputs.
  output logic [fpm_pkg::NSTAGE-1:0] stageForce,
  output logic [fpm_pkg::NRELAY-1:0] relayOut,
  output logic internal_fault_output,
  output logic serialAlarm,
  output logic outOfService
);
  import fpm_pkg::*;

  // ***************************************************************
  // Millisecond tick and input synchronisers.
  // ***************************************************************
  logic [15:0] tickCnt_r;
  logic tick;
  logic [1:0] syncA_r, syncB_r;
  logic linkA_r, linkB_r, supA_r, supB_r;

  // Free-running divider for the tick.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt_r <= 16'h0000;
    end else if (tickCnt_r == 16'(TICK_CYC - 1)) begin
      tickCnt_r <= 16'h0000;
    end else begin
      tickCnt_r <= tickCnt_r + 16'h0001;
    end
  end
  assign tick = (tickCnt_r == 16'(TICK_CYC - 1));

  // Two flip-flops on every pin input.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= 2'h0;
      syncB_r <= 2'h0;
      linkA_r <= 1'b0;
      linkB_r <= 1'b0;
      supA_r <= 1'b0;
      supB_r <= 1'b0;
    end else begin
      syncA_r <= {btnProg, btnStep};
      syncB_r <= syncA_r;
      linkA_r <= serLinkOk;
      linkB_r <= linkA_r;
      supA_r <= supplyLost;
      supB_r <= supA_r;
    end
  end

  // ***************************************************************
  // Debounce and hold timing, index 0 step and 1 program.
  // ***************************************************************
  logic [1:0] pressed_r, rel, c1, c5;
  logic [15:0] hold_r [2];

  for (genvar b = 0; b < 2; b++) begin : g_btn
    logic [15:0] deb_r;
    // Debounce on the tick, then count held milliseconds.
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        deb_r <= 16'h0000;
        pressed_r[b] <= 1'b0;
        hold_r[b] <= 16'h0000;
      end else begin
        if (syncB_r[b] == pressed_r[b]) begin
          deb_r <= 16'h0000;
        end else if (tick && deb_r == DEB_TICKS - 16'h0001) begin
          deb_r <= 16'h0000;
          pressed_r[b] <= syncB_r[b];
        end else if (tick) begin
          deb_r <= deb_r + 16'h0001;
        end
        if (!pressed_r[b]) begin
          hold_r[b] <= 16'h0000;
        end else if (tick && hold_r[b] != HOLD5_TICKS) begin
          hold_r[b] <= hold_r[b] + 16'h0001;
        end
      end
    end
    assign rel[b] = pressed_r[b] && tick && deb_r == DEB_TICKS - 16'h0001
      && !syncB_r[b];
    assign c1[b] = pressed_r[b] && tick && hold_r[b] == HOLD1_TICKS - 16'h0001;
    assign c5[b] = pressed_r[b] && tick && hold_r[b] == HOLD5_TICKS - 16'h0001;
  end

  // ***************************************************************
  // Press events; a press used by a chord or a long hold is spent.
  // ***************************************************************
  logic used_r;
  logic evBoth, evProgRel, evProgLongRel, evProg5, evStepRel, evStep1;

  assign evBoth = pressed_r[0] && pressed_r[1] && !used_r;
  assign evProg5 = c5[1] && !pressed_r[0] && !used_r;
  assign evProgRel = rel[1] && !used_r && hold_r[1] != HOLD5_TICKS;
  assign evProgLongRel = evProgRel && hold_r[1] >= HOLD1_TICKS;
  assign evStepRel = rel[0] && !used_r && hold_r[0] < HOLD1_TICKS;
  assign evStep1 = c1[0] && !pressed_r[1] && !used_r;

  // Spent flag clears once both buttons are up.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      used_r <= 1'b0;
    end else if (!pressed_r[0] && !pressed_r[1]) begin
      used_r <= 1'b0;
    end else if (evBoth || evProg5) begin
      used_r <= 1'b1;
    end
  end

  // ***************************************************************
  // Setting banks with checksums.
  // ***************************************************************
  logic [15:0] bankA_r [WORDS];
  logic [15:0] bankB_r [WORDS];
  logic [15:0] sumA, sumB, sumA_r, sumB_r;
  logic okA, okB;
  logic panelWr;
  logic [3:0] panelIdx;
  logic [15:0] panelData;
  logic busSetWr;
  logic [3:0] busIdx;

  // Each bank holds its words and a stored checksum register.
  always_comb begin
    sumA = 16'h0000;
    sumB = 16'h0000;
    for (int i = 0; i < WORDS; i++) begin
      sumA = sumA + bankA_r[i];
      sumB = sumB + bankB_r[i];
    end
  end
  assign okA = (sumA == sumA_r);
  assign okB = (sumB == sumB_r);
  assign busIdx = bus.addr[5:2];
  assign busSetWr = bus.wr && bus.addr[7:6] == REG_SET_BASE[7:6]
    && busIdx < 4'(WORDS) && bus.addr[1:0] == 2'b00;

  // Writes go to both banks; a bad bank is copied from the good one.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < WORDS; i++) begin
        bankA_r[i] <= DEF_ZERO;
        bankB_r[i] <= DEF_ZERO;
      end
      bankA_r[W_ADDR] <= DEF_ADDR;
      bankB_r[W_ADDR] <= DEF_ADDR;
      bankA_r[W_RATE] <= DEF_RATE;
      bankB_r[W_RATE] <= DEF_RATE;
      bankA_r[W_PASS] <= DEF_PASS;
      bankB_r[W_PASS] <= DEF_PASS;
      sumA_r <= DEF_ADDR + DEF_RATE + DEF_PASS;
      sumB_r <= DEF_ADDR + DEF_RATE + DEF_PASS;
    end else if (panelWr || busSetWr) begin
      bankA_r[panelWr ? panelIdx : busIdx] <= panelWr ? panelData
        : bus.wdata[15:0];
      bankB_r[panelWr ? panelIdx : busIdx] <= panelWr ? panelData
        : bus.wdata[15:0];
      sumA_r <= sumA - bankA_r[panelWr ? panelIdx : busIdx]
        + (panelWr ? panelData : bus.wdata[15:0]);
      sumB_r <= sumA - bankA_r[panelWr ? panelIdx : busIdx]
        + (panelWr ? panelData : bus.wdata[15:0]);
    end else if (bus.wr && bus.addr == REG_DISTURB) begin
      if (bus.wdata[0]) bankA_r[0] <= ~bankA_r[0];
      if (bus.wdata[1]) bankB_r[0] <= ~bankB_r[0];
    end else if (!okA && okB) begin
      for (int i = 0; i < WORDS; i++) bankA_r[i] <= bankB_r[i];
      sumA_r <= sumB_r;
    end else if (okA && !okB) begin
      for (int i = 0; i < WORDS; i++) bankB_r[i] <= bankA_r[i];
      sumB_r <= sumA_r;
    end
  end

  // Both banks bad takes the relay out of service.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      outOfService <= 1'b0;
    end else if (!okA && !okB) begin
      outOfService <= 1'b1;
    end
  end

  // Words in use come from whichever bank checks good.
  function automatic logic [15:0] setWord(input logic [3:0] i);
    setWord = okA ? bankA_r[i] : bankB_r[i];
  endfunction

  // ***************************************************************
  // Bus monitor and recorded registers.
  // ***************************************************************
  logic [7:0] mon_r;
  logic [15:0] monTick_r;
  logic [11:0] recVal_r;
  logic [11:0] recCount_r;
  logic recClr;

  // Monitor reads zero while linked, else scrolls 1 to 255.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mon_r <= 8'h01;
      monTick_r <= 16'h0000;
    end else if (linkB_r) begin
      mon_r <= 8'h00;
      monTick_r <= 16'h0000;
    end else if (tick && monTick_r == MON_TICKS - 16'h0001) begin
      monTick_r <= 16'h0000;
      mon_r <= (mon_r == 8'hff || mon_r == 8'h00) ? 8'h01
        : mon_r + 8'h01;
    end else if (tick) begin
      monTick_r <= monTick_r + 16'h0001;
    end
  end

  // Recorded value is volatile; the fault count is kept on clear.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      recVal_r <= 12'h000;
      recCount_r <= 12'h000;
    end else if (supB_r) begin
      recVal_r <= 12'h000;
      recCount_r <= 12'h000;
    end else if (faultEv) begin
      recVal_r <= faultVal;
      recCount_r <= recCount_r + 12'h001;
    end else if (recClr) begin
      recVal_r <= 12'h000;
    end
  end

  // ***************************************************************
  // Menu state machine.
  // ***************************************************************
  fpm_mode_t mode_r;
  logic [2:0] item_r, pos_r;
  logic [1:0] sub_r, subMax, dp_r;
  logic [11:0] edit_r;
  logic [7:0] sw_r;
  logic [3:0] swPos_r, testSel_r, wIdx;
  logic [15:0] dash_r;
  logic [15:0] curWord, swgWord, addrWord;

  // Words in use at the current position, switchgroup and address.
  always_comb begin
    curWord = setWord(wIdx);
    swgWord = setWord(W_SWG);
    addrWord = setWord(W_ADDR);
  end

  // Submenu count and word index of the current position.
  always_comb begin
    subMax = (item_r < IT_SWG) ? SUB_MAX_SET : (item_r == IT_SWG)
      ? SUB_MAX_SWG : (item_r == IT_REGA) ? SUB_MAX_REGA : 2'h0;
    wIdx = (item_r < IT_SWG) ? {item_r[1:0], 1'b0} + 4'(sub_r == 2'h2)
      : (item_r == IT_SWG) ? W_SWG : (sub_r == 2'h1) ? W_RATE : W_PASS;
  end
  assign panelWr = evBoth && ((mode_r == MD_SET && pos_r == POS_WHOLE)
    || (mode_r == MD_SWG && swPos_r == SW_FINAL));
  assign panelIdx = wIdx;
  assign panelData = (mode_r == MD_SWG) ? {8'h00, sw_r}
    : {dp_r, 2'b00, edit_r};
  assign recClr = evBoth && mode_r == MD_MAIN && item_r == IT_REC;

  // Mode, menu position and editor state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= MD_MAIN;
      item_r <= 3'h0;
      sub_r <= 2'h0;
      pos_r <= 3'h0;
      dp_r <= 2'h0;
      edit_r <= 12'h000;
      sw_r <= 8'h00;
      swPos_r <= SW_FINAL;
      testSel_r <= 4'h0;
    end else begin
      unique case (mode_r)
        MD_MAIN: begin
          if (evStepRel) begin
            item_r <= (item_r == MAIN_LAST) ? 3'h0 : item_r + 3'h1;
          end else if (evProgLongRel && subMax != 2'h0) begin
            mode_r <= MD_SUB;
            sub_r <= 2'h1;
          end else if (evProg5 && item_r == IT_REG0) begin
            mode_r <= MD_TEST;
            testSel_r <= 4'h0;
          end
        end
        MD_SUB: begin
          if (evStep1 && sub_r == subMax) begin
            mode_r <= MD_MAIN;
            sub_r <= 2'h0;
          end else if (evStep1) begin
            sub_r <= sub_r + 2'h1;
          end else if (evProg5 && item_r == IT_SWG) begin
            mode_r <= MD_SWG;
            sw_r <= swgWord[7:0];
            swPos_r <= SW_FINAL;
          end else if (evProg5
              && !(item_r == IT_REGA && sub_r == SUB_MON)) begin
            mode_r <= MD_SET;
            pos_r <= POS_WHOLE;
            edit_r <= curWord[11:0];
            dp_r <= curWord[15:14];
          end
        end
        MD_SET: begin
          if (evProg5 || panelWr) begin
            mode_r <= MD_SUB;
          end else if (evProgRel) begin
            pos_r <= (pos_r == POS_WHOLE) ? 3'h0 : pos_r + 3'h1;
          end else if (evStepRel && pos_r == POS_DP) begin
            dp_r <= (dp_r == DP_LAST) ? 2'h0 : dp_r + 2'h1;
          end else if (evStepRel && pos_r < POS_DP) begin
            edit_r[pos_r*4 +: 4] <= (edit_r[pos_r*4 +: 4] == 4'h9) ? 4'h0
              : edit_r[pos_r*4 +: 4] + 4'h1;
          end
        end
        MD_SWG: begin
          if (evProg5 || panelWr) begin
            mode_r <= MD_SUB;
          end else if (evProgRel) begin
            swPos_r <= (swPos_r == SW_FINAL) ? 4'h0 : swPos_r + 4'h1;
          end else if (evStepRel && swPos_r != SW_FINAL) begin
            sw_r[swPos_r[2:0]] <= ~sw_r[swPos_r[2:0]];
          end
        end
        MD_TEST: begin
          if (evProg5) begin
            mode_r <= MD_MAIN;
          end else if (evProgRel) begin
            testSel_r <= (testSel_r == TEST_FAULT) ? 4'h0
              : testSel_r + 4'h1;
          end
        end
      endcase
    end
  end

  // Dash flash lasts a fixed time after each store from the panel.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dash_r <= 16'h0000;
    end else if (panelWr) begin
      dash_r <= DASH_TICKS;
    end else if (tick && dash_r != 16'h0000) begin
      dash_r <= dash_r - 16'h0001;
    end
  end

  // ***************************************************************
  // Trip test outputs.
  // ***************************************************************
  logic faultTest;

  assign faultTest = mode_r == MD_TEST && testSel_r == TEST_FAULT
    && pressed_r[0] && hold_r[0] >= HOLD1_TICKS;

  // Forced stage, relay matrix and fault outputs.
  logic [31:0] matrix_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stageForce <= '0;
      relayOut <= '0;
      internal_fault_output <= 1'b0;
      serialAlarm <= 1'b0;
    end else begin
      for (int s = 0; s < NSTAGE; s++) begin
        stageForce[s] <= mode_r == MD_TEST && testSel_r == 4'(s)
          && pressed_r[0] && pressed_r[1];
      end
      for (int r = 0; r < NRELAY; r++) begin
        relayOut[r] <= |(stageForce & matrix_r[r*NSTAGE +: NSTAGE]);
      end
      internal_fault_output <= faultTest || outOfService;
      serialAlarm <= outOfService;
    end
  end

  // ***************************************************************
  // Display.
  // ***************************************************************
  function automatic logic [11:0] toBcd(input logic [7:0] v);
    logic [19:0] s;
    s = {12'h000, v};
    for (int i = 0; i < 8; i++) begin
      for (int d = 0; d < 3; d++) begin
        if (s[8+4*d +: 4] > 4'h4) s[8+4*d +: 4] = s[8+4*d +: 4] + 4'h3;
      end
      s = s << 1;
    end
    toBcd = s[19:8];
  endfunction

  // Display contents chosen by mode, registered.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      disp <= '0;
    end else begin
      disp.itemLed <= 8'h01 << item_r;
      disp.itemLedFlash <= 1'b0;
      disp.redOn <= 1'b0;
      disp.redFlash <= 1'b0;
      disp.red <= {1'b0, item_r};
      disp.greenFlash <= 4'h0;
      disp.dashes <= dash_r != 16'h0000;
      disp.dp <= 2'h0;
      disp.green <= 12'h000;
      unique case (mode_r)
        MD_MAIN: begin
          disp.green <= (item_r < IT_SWG) ? curWord[11:0]
            : (item_r == IT_SWG) ? toBcd(swgWord[7:0])
            : (item_r == IT_REC) ? recVal_r
            : (item_r == IT_REGA) ? addrWord[11:0] : 12'h000;
          disp.dp <= (item_r < IT_SWG) ? curWord[15:14] : 2'h0;
        end
        MD_SUB: begin
          disp.redOn <= 1'b1;
          disp.redFlash <= 1'b1;
          disp.red <= {2'b00, sub_r};
          disp.green <= (item_r == IT_SWG) ? toBcd(swgWord[7:0])
            : (item_r == IT_REGA && sub_r == SUB_MON) ? toBcd(mon_r)
            : curWord[11:0];
          disp.dp <= (item_r == IT_SWG || (item_r == IT_REGA
            && sub_r == SUB_MON)) ? 2'h0 : curWord[15:14];
        end
        MD_SET: begin
          disp.redOn <= 1'b1;
          disp.red <= {2'b00, sub_r};
          disp.green <= edit_r;
          disp.dp <= dp_r;
          disp.greenFlash <= (pos_r == POS_WHOLE) ? 4'hf
            : 4'h1 << pos_r;
        end
        MD_SWG: begin
          disp.redOn <= 1'b1;
          disp.red <= (swPos_r == SW_FINAL) ? {2'b00, sub_r}
            : swPos_r + 4'h1;
          disp.green <= (swPos_r == SW_FINAL) ? toBcd(sw_r)
            : {11'h000, sw_r[swPos_r[2:0]]};
          disp.greenFlash <= 4'hf;
        end
        MD_TEST: begin
          disp.itemLed <= (testSel_r == TEST_FAULT) ? 8'h00
            : 8'h01 << testSel_r[3:1];
          disp.itemLedFlash <= testSel_r != TEST_FAULT;
          disp.greenFlash <= 4'h7;
        end
      endcase
    end
  end

  // ***************************************************************
  // Register port.
  // ***************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      matrix_r <= MATRIX_RST;
    end else if (bus.wr && bus.addr == REG_MATRIX) begin
      matrix_r <= bus.wdata;
    end
  end

  // Read data for one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busRdata <= 32'h0000_0000;
    end else if (!bus.rd) begin
      busRdata <= 32'h0000_0000;
    end else if (bus.addr == REG_STATUS) begin
      busRdata <= {24'h000000, okB, okA, outOfService, 2'b00, mode_r};
    end else if (bus.addr == REG_MATRIX) begin
      busRdata <= matrix_r;
    end else if (bus.addr == REG_MONITOR) begin
      busRdata <= {24'h000000, mon_r};
    end else if (bus.addr == REG_REC) begin
      busRdata <= {4'h0, recCount_r, 4'h0, recVal_r};
    end else if (bus.addr[7:6] == REG_SET_BASE[7:6] && busIdx < 4'(WORDS)
        && bus.addr[1:0] == 2'b00) begin
      busRdata <= {16'h0000, setWord(busIdx)};
    end else begin
      busRdata <= 32'h0000_0000;
    end
  end

endmodule

/* verilog/fpm_pkg.sv */
// Package of constants, types and carriers for the front-panel menu block.
package fpm_pkg;

  // ***************************************************************
  // Clock and timing.
  // ***************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_HZ = 1000;
  localparam int TICK_CYC_DEF = CLK_HZ / TICK_HZ;
  localparam int DEBOUNCE_MS = 20;
  localparam int HOLD_SHORT_MS = 1000;
  localparam int HOLD_LONG_MS = 5000;
  localparam int MON_STEP_MS = 10;
  localparam int DASH_MS = 500;
  localparam logic [15:0] DEB_TICKS = 16'(DEBOUNCE_MS * TICK_HZ / 1000);
  localparam logic [15:0] HOLD1_TICKS = 16'(HOLD_SHORT_MS * TICK_HZ / 1000);
  localparam logic [15:0] HOLD5_TICKS = 16'(HOLD_LONG_MS * TICK_HZ / 1000);
  localparam logic [15:0] MON_TICKS = 16'(MON_STEP_MS * TICK_HZ / 1000);
  localparam logic [15:0] DASH_TICKS = 16'(DASH_MS * TICK_HZ / 1000);

  // ***************************************************************
  // Menu layout and setting words.
  // ***************************************************************
  localparam logic [2:0] MAIN_LAST = 3'h7;
  localparam logic [2:0] IT_SWG = 3'h4;
  localparam logic [2:0] IT_REC = 3'h5;
  localparam logic [2:0] IT_REG0 = 3'h6;
  localparam logic [2:0] IT_REGA = 3'h7;
  localparam int WORDS = 12;
  localparam logic [3:0] W_SWG = 4'h8;
  localparam logic [3:0] W_ADDR = 4'h9;
  localparam logic [3:0] W_RATE = 4'ha;
  localparam logic [3:0] W_PASS = 4'hb;
  localparam logic [15:0] DEF_ADDR = 16'h0001;
  localparam logic [15:0] DEF_RATE = 16'h4096;
  localparam logic [15:0] DEF_PASS = 16'h0001;
  localparam logic [15:0] DEF_ZERO = 16'h0000;
  localparam logic [1:0] SUB_MAX_SET = 2'h2;
  localparam logic [1:0] SUB_MAX_SWG = 2'h1;
  localparam logic [1:0] SUB_MAX_REGA = 2'h3;
  localparam logic [1:0] SUB_MON = 2'h2;
  localparam logic [2:0] POS_DP = 3'h3;
  localparam logic [2:0] POS_WHOLE = 3'h4;
  localparam logic [1:0] DP_LAST = 2'h2;
  localparam logic [3:0] SW_FINAL = 4'h8;
  localparam logic [3:0] TEST_FAULT = 4'h8;
  localparam int NSTAGE = 8;
  localparam int NRELAY = 4;

  // ***************************************************************
  // Register map.
  // ***************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MATRIX = 8'h04;
  localparam logic [7:0] REG_DISTURB = 8'h08;
  localparam logic [7:0] REG_MONITOR = 8'h0c;
  localparam logic [7:0] REG_REC = 8'h10;
  localparam logic [7:0] REG_SET_BASE = 8'h40;
  localparam logic [31:0] MATRIX_RST = 32'h0000_0000;

  // ***************************************************************
  // Types.
  // ***************************************************************
  typedef enum logic [2:0] {MD_MAIN, MD_SUB, MD_SET, MD_SWG, MD_TEST}
    fpm_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fpm_bus_t;

  typedef struct packed {
    logic [7:0] itemLed;
    logic itemLedFlash;
    logic redOn;
    logic redFlash;
    logic [3:0] red;
    logic [11:0] green;
    logic [1:0] dp;
    logic [3:0] greenFlash;
    logic dashes;
  } fpm_disp_t;

endpackage

/* bench/fpm_asserts.sv */
// Checker of the panel block's output relations.
`timescale 1ns/100ps
module fpm_asserts (
  // Clock, reset and watched ports.
  input wire logic clk,
  input wire logic sys_rst,
  input wire fpm_pkg::fpm_bus_t bus,
  input wire logic [31:0] busRdata,
  input wire fpm_pkg::fpm_disp_t disp,
  input wire logic [fpm_pkg::NSTAGE-1:0] stageForce,
  input wire logic [fpm_pkg::NRELAY-1:0] relayOut,
  input wire logic internal_fault_output,
  input wire logic serialAlarm,
  input wire logic outOfService
);
  import fpm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_alarm; serialAlarm == $past(outOfService); endproperty
  property p_sticky; outOfService |=> outOfService; endproperty
  property p_fault; outOfService |=> internal_fault_output; endproperty
  property p_relay; stageForce == '0 |=> relayOut == '0; endproperty
  property p_idle; !bus.rd |=> busRdata == '0; endproperty
  property p_item; $onehot0(disp.itemLed); endproperty
  property p_bcd; disp.green[3:0] < 4'ha && disp.green[7:4] < 4'ha
    && disp.green[11:8] < 4'ha; endproperty
  property p_dp; disp.dp <= DP_LAST; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm lag");
  a_sticky: assert property (p_sticky) else $error("oos drop");
  a_fault: assert property (p_fault) else $error("no fault");
  a_relay: assert property (p_relay) else $error("relay");
  a_idle: assert property (p_idle) else $error("rdata");
  a_item: assert property (p_item) else $error("item led");
  a_bcd: assert property (p_bcd) else $error("digit");
  a_dp: assert property (p_dp) else $error("point");
  c_oos: cover property ($rose(outOfService));
  c_dash: cover property ($rose(disp.dashes));
  c_sub: cover property ($rose(disp.redFlash));
endmodule

/* bench/fpm_operator.sv */
// Operator model pressing the two panel buttons.
`timescale 1ns/100ps
module fpm_operator #(
  parameter int TICK_CYC = 4
) (
  // Clock and button pins.
  input wire logic clk,
  output logic btnStep,
  output logic btnProg
);
  // Buttons are up at power-on.
  initial begin
    btnStep = 1'b0;
    btnProg = 1'b0;
  end
  // Holds the chosen buttons for ms milliseconds, then lets go and idles.
  task automatic press(input logic s, input logic p, input int ms);
    @(posedge clk);
    btnStep <= s;
    btnProg <= p;
    repeat (ms * TICK_CYC) @(posedge clk);
    btnStep <= 1'b0;
    btnProg <= 1'b0;
    repeat (60 * TICK_CYC) @(posedge clk);
  endtask
endmodule

/* bench/test_front_panel_setting_menu_fsm.sv */
// Self-checking bench of the front-panel menu block.
`timescale 1ns/100ps
module test_front_panel_setting_menu_fsm;
  import fpm_pkg::*;
  logic clk, sys_rst, btnStep, btnProg, serLinkOk, supplyLost, faultEv;
  logic [11:0] faultVal;
  fpm_bus_t bus;
  logic [31:0] busRdata;
  fpm_disp_t disp;
  logic [NSTAGE-1:0] stageForce;
  logic [NRELAY-1:0] relayOut;
  logic internal_fault_output, serialAlarm, outOfService;
  int n_mismatch, check_count;
  fpm_menu #(.TICK_CYC(4)) dut (.clk(clk), .sys_rst(sys_rst),
    .btnStep(btnStep), .btnProg(btnProg), .serLinkOk(serLinkOk),
    .supplyLost(supplyLost), .faultEv(faultEv), .faultVal(faultVal),
    .bus(bus), .busRdata(busRdata), .disp(disp), .stageForce(stageForce),
    .relayOut(relayOut), .internal_fault_output(internal_fault_output),
    .serialAlarm(serialAlarm), .outOfService(outOfService));
  fpm_operator #(.TICK_CYC(4)) op (.clk(clk), .btnStep(btnStep),
    .btnProg(btnProg));
  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch.
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // One-cycle read; the data stand in the next cycle only.
  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 cmp(nm, e, busRdata & m);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  // Main sequence of tests.
  initial begin
    sys_rst = 1'b1;
    bus = '0;
    serLinkOk = 1'b0;
    supplyLost = 1'b0;
    faultEv = 1'b0;
    faultVal = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rchk("addr", 8'h64, 32'hffff, 32'h0001);
    rchk("rate", 8'h68, 32'hffff, 32'h4096);
    rchk("pass", 8'h6c, 32'hffff, 32'h0001);
    rchk("hole", 8'h3c, 32'hffffffff, 32'h0);
    cmp("led", 32'h1, 32'(disp.itemLed));
    wr(8'h04, 32'h0000_00ff);
    rchk("matrix", 8'h04, 32'hffffffff, 32'h0000_00ff);
    op.press(1'b0, 1'b1, 2000);
    rchk("mode", 8'h00, 32'h7, 32'h1);
    cmp("red", 32'h1, 32'(disp.red));
    op.press(1'b0, 1'b1, 5300);
    rchk("mode", 8'h00, 32'h7, 32'h2);
    op.press(1'b0, 1'b1, 300);
    cmp("flash", 32'h1, 32'(disp.greenFlash));
    op.press(1'b1, 1'b0, 200);
    repeat (4) op.press(1'b0, 1'b1, 300);
    op.press(1'b1, 1'b1, 200);
    cmp("dash", 32'h1, 32'(disp.dashes));
    cmp("red", 32'h1, 32'(disp.red));
    rchk("mode", 8'h00, 32'h7, 32'h1);
    rchk("word", 8'h40, 32'h0fff, 32'h0001);
    op.press(1'b1, 1'b0, 1200);
    cmp("red", 32'h2, 32'(disp.red));
    op.press(1'b1, 1'b0, 1200);
    rchk("mode", 8'h00, 32'h7, 32'h0);
    cmp("led", 32'h1, 32'(disp.itemLed));
    @(posedge clk);
    faultEv <= 1'b1;
    faultVal <= 12'h123;
    @(posedge clk);
    faultEv <= 1'b0;
    rchk("rec", 8'h10, 32'hffffffff, 32'h0001_0123);
    repeat (5) op.press(1'b1, 1'b0, 200);
    op.press(1'b1, 1'b1, 200);
    rchk("clr", 8'h10, 32'hffffffff, 32'h0001_0000);
    supplyLost <= 1'b1;
    repeat (6) @(posedge clk);
    supplyLost <= 1'b0;
    rchk("rec", 8'h10, 32'hffffffff, 32'h0);
    op.press(1'b1, 1'b0, 200);
    op.press(1'b0, 1'b1, 5300);
    rchk("mode", 8'h00, 32'h7, 32'h4);
    fork
      op.press(1'b1, 1'b1, 200);
      begin
        repeat (400) @(posedge clk);
        #1 cmp("force", 32'h1, 32'(stageForce));
        cmp("relay", 32'h1, 32'(relayOut));
      end
    join
    serLinkOk <= 1'b1;
    repeat (10) @(posedge clk);
    rchk("mon", 8'h0c, 32'hff, 32'h0);
    wr(8'h08, 32'h1);
    repeat (5) @(posedge clk);
    rchk("banks", 8'h00, 32'he0, 32'hc0);
    wr(8'h08, 32'h3);
    repeat (5) @(posedge clk);
    cmp("oos", 32'h7, {29'h0, outOfService, serialAlarm,
      internal_fault_output});
    final_report();
  end
endmodule
bind fpm_menu fpm_asserts chk (.clk(clk), .sys_rst(sys_rst), .bus(bus),
  .busRdata(busRdata), .disp(disp), .stageForce(stageForce),
  .relayOut(relayOut), .internal_fault_output(internal_fault_output),
  .serialAlarm(serialAlarm), .outOfService(outOfService));
